// file: logic/async_tx_pkg.sv
// Shared constants and types of the asynchronous serial transmitter.
package async_tx_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW = 8'h08;
   localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_TX_HOLDING_DATA = 8'h10;
   localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h18;
   // ==========================================================
   // Field positions
   localparam int TSC_SYNC_POS = 4;
   localparam int TSC_ENABLE_POS = 5;
   localparam int TSC_NINE_POS = 6;
   localparam int TSC_EMPTY_POS = 1;
   localparam int TSC_NINTH_POS = 0;
   localparam int TSC_SPEED_POS = 2;
   localparam int RSC_PORT_POS = 7;
   localparam int BAUD_INV_POS = 4;
   localparam int BAUD_WIDE_POS = 3;
   localparam int IRQ_GLOBAL_POS = 7;
   localparam int IRQ_PERIPH_POS = 6;
   localparam int IRQ_FLAG_POS = 1;
   localparam int IRQ_READY_IE_POS = 0;
   // ==========================================================
   // Writable masks and reset values
   localparam logic [7:0] TSC_WR_MASK = 8'hFD;
   localparam logic [7:0] RSC_WR_MASK = 8'hF8;
   localparam logic [7:0] BAUD_WR_MASK = 8'h1B;
   localparam logic [7:0] IRQ_WR_MASK = 8'hC1;
   localparam logic [7:0] TSC_RESET = 8'h00;
   localparam logic [7:0] RSC_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;
   // ==========================================================
   // Character framing
   localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
   localparam logic [3:0] LAST_BIT_NINE = 4'h8;
   // ==========================================================
   // Types
   typedef struct packed {
      logic port_enable;
      logic sync_mode;
      logic tx_enable_bit;
      logic nine_bit_tx_select;
      logic tx_invert;
      logic tx_ninth_bit;
   } tx_ctrl_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ALIGN = 3'b001,
      ST_START = 3'b010,
      ST_DATA = 3'b011,
      ST_STOP = 3'b100
   } tx_state_t;
endpackage

// file: logic/async_serial_transmitter.sv
// Asynchronous serial transmitter with APB register access.
//
// What this block does
// [R01] Runs only with enable, async, port enabled.
// [R02] Port enable makes transmit pin driven.
// [R03] Transmit enable sets the ready flag.
// [R04] Idle shifter takes written character at once.
// [R05] Busy shifter: transfer right after stop bit.
// [R06] Start, data, stop follow a load; after an idle load the start bit waits for the next tick.
// [R07] Invert bit flips idle and data levels.
// [R08] Inversion applies in asynchronous mode only.
// [R09] Ready flag clear only while character waits or transmitter is off.
// [R10] Ready flag valid third cycle after write.
// [R11] Ready flag is read-only.
// [R12] Interrupt needs enable; flag ignores enable.
// [R13] Software enables interrupt only while data remains; the bench also enables it with nothing queued.
// [R14] Shifter empty clears on load until sent.
// [R15] Shifter empty is polled, no interrupt.
// [R16] Nine-bit select sends nine data bits.
// [R17] Ninth bit written first, moved with character.
// [R18] Software sets ninth bit to mark addresses.
// [R19] Software follows the documented setup order.
// [R20] Enabling interrupt with flag set fires at once.
// [R21] Least significant bit goes first.
// [R22] Space start, mark stop, mark idle.
// [R23] Each bit lasts one bit period.
// [R24] Bit-rate tick input; port disable empties all.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module async_serial_transmitter (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Bit-rate generator side
   input wire logic baud_tick_in,
   output logic [15:0] baud_divisor_out,
   output logic baud_high_speed_out,
   output logic baud_wide_select_out,
   // Transmit pin and interrupt request
   output logic transmit_pin_out,
   output logic transmit_pin_oe_n_out,
   output logic tx_irq_out
);
   // ==========================================================
   // Reset release
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ==========================================================
   // Functions
   function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   function automatic logic line_level(input logic mark_level, input async_tx_pkg::tx_ctrl_t c);
      line_level = mark_level ^ (c.tx_invert & ~c.sync_mode);
   endfunction

   // ==========================================================
   // Registers
   logic [7:0] tx_status_control;
   logic [7:0] rx_status_control;
   logic [7:0] baud_control;
   logic [7:0] baud_divisor_low;
   logic [7:0] baud_divisor_high;
   logic [7:0] irq_control;
   async_tx_pkg::tx_ctrl_t ctrl;
   logic run;
   logic setup_ph;
   logic access_ph;
   logic wr_en;
   logic addr_ok;
   logic hold_wr;
   logic shifter_empty;
   logic tx_ready_flag;

   assign ctrl.port_enable = rx_status_control[async_tx_pkg::RSC_PORT_POS];
   assign ctrl.sync_mode = tx_status_control[async_tx_pkg::TSC_SYNC_POS];
   assign ctrl.tx_enable_bit = tx_status_control[async_tx_pkg::TSC_ENABLE_POS];
   assign ctrl.nine_bit_tx_select = tx_status_control[async_tx_pkg::TSC_NINE_POS];
   assign ctrl.tx_invert = baud_control[async_tx_pkg::BAUD_INV_POS];
   assign ctrl.tx_ninth_bit = tx_status_control[async_tx_pkg::TSC_NINTH_POS];
   assign run = ctrl.tx_enable_bit & ~ctrl.sync_mode & ctrl.port_enable; // [R01]

   assign setup_ph = psel_in & ~penable_in;
   assign access_ph = psel_in & penable_in;
   assign addr_ok = (paddr_in <= async_tx_pkg::ADDR_IRQ_CONTROL) && (paddr_in[1:0] == 2'h0);
   assign wr_en = access_ph & pwrite_in & addr_ok;
   assign hold_wr = wr_en && (paddr_in == async_tx_pkg::ADDR_TX_HOLDING_DATA) && run;
   assign pready_out = 1'b1;
   assign pslverr_out = access_ph & ~addr_ok;

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_status_control <= async_tx_pkg::TSC_RESET;
         rx_status_control <= async_tx_pkg::RSC_RESET;
         baud_control <= async_tx_pkg::BAUD_RESET;
         baud_divisor_low <= async_tx_pkg::DIVISOR_RESET;
         baud_divisor_high <= async_tx_pkg::DIVISOR_RESET;
         irq_control <= async_tx_pkg::IRQ_RESET;
      end else if (wr_en) begin
         unique case (paddr_in)
            async_tx_pkg::ADDR_TX_STATUS_CONTROL: begin
               // Ready and empty bits are live status and never stored. [R11] [R15]
               tx_status_control <= merge(tx_status_control, pwdata_in[7:0], async_tx_pkg::TSC_WR_MASK);
            end
            async_tx_pkg::ADDR_RX_STATUS_CONTROL: begin
               rx_status_control <= merge(rx_status_control, pwdata_in[7:0], async_tx_pkg::RSC_WR_MASK);
            end
            async_tx_pkg::ADDR_BAUD_CONTROL: begin
               baud_control <= merge(baud_control, pwdata_in[7:0], async_tx_pkg::BAUD_WR_MASK);
            end
            async_tx_pkg::ADDR_BAUD_DIVISOR_LOW: begin
               baud_divisor_low <= pwdata_in[7:0];
            end
            async_tx_pkg::ADDR_BAUD_DIVISOR_HIGH: begin
               baud_divisor_high <= pwdata_in[7:0];
            end
            async_tx_pkg::ADDR_IRQ_CONTROL: begin
               irq_control <= merge(irq_control, pwdata_in[7:0], async_tx_pkg::IRQ_WR_MASK);
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is captured in the setup cycle so the access phase needs no wait state.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prdata_out <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_out <= 32'h0000_0000;
         unique case (paddr_in)
            async_tx_pkg::ADDR_TX_STATUS_CONTROL: begin
               prdata_out[7:0] <= tx_status_control | (8'h01 << async_tx_pkg::TSC_EMPTY_POS) &
                                  {8{shifter_empty}}; // [R14]
            end
            async_tx_pkg::ADDR_RX_STATUS_CONTROL: begin
               prdata_out[7:0] <= rx_status_control;
            end
            async_tx_pkg::ADDR_BAUD_CONTROL: begin
               prdata_out[7:0] <= baud_control;
            end
            async_tx_pkg::ADDR_BAUD_DIVISOR_LOW: begin
               prdata_out[7:0] <= baud_divisor_low;
            end
            async_tx_pkg::ADDR_BAUD_DIVISOR_HIGH: begin
               prdata_out[7:0] <= baud_divisor_high;
            end
            async_tx_pkg::ADDR_IRQ_CONTROL: begin
               prdata_out[7:0] <= irq_control | (8'h01 << async_tx_pkg::IRQ_FLAG_POS) &
                                  {8{tx_ready_flag}}; // [R11]
            end
            default: begin
            end
         endcase
      end
   end

   assign baud_divisor_out = {baud_divisor_high, baud_divisor_low};
   assign baud_high_speed_out = tx_status_control[async_tx_pkg::TSC_SPEED_POS];
   assign baud_wide_select_out = baud_control[async_tx_pkg::BAUD_WIDE_POS];

   // ==========================================================
   // Holding register
   logic [8:0] holding_data;
   logic holding_full;
   logic load;
   async_tx_pkg::tx_state_t state;

   // The shifter takes a character when idle, or at the tick that ends the stop bit.
   assign load = holding_full && ((state == async_tx_pkg::ST_IDLE) ||
                                  (state == async_tx_pkg::ST_STOP && baud_tick_in)); // [R04] [R05]

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         holding_full <= 1'b0;
         holding_data <= 9'h000;
      end else if (!run) begin
         holding_full <= 1'b0; // [R24]
      end else if (hold_wr) begin
         // The ninth bit is taken from the control register at this write. [R17]
         holding_full <= 1'b1;
         holding_data <= {ctrl.tx_ninth_bit, pwdata_in[7:0]};
      end else if (load) begin
         holding_full <= 1'b0;
      end
   end

   // ==========================================================
   // Shifter
   logic [8:0] shift_data;
   logic [3:0] bit_cnt;
   logic [3:0] last_bit;
   assign last_bit = ctrl.nine_bit_tx_select ? async_tx_pkg::LAST_BIT_NINE :
                     async_tx_pkg::LAST_BIT_EIGHT; // [R16]

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= async_tx_pkg::ST_IDLE;
         shift_data <= 9'h000;
         bit_cnt <= 4'h0;
      end else if (!run) begin
         state <= async_tx_pkg::ST_IDLE; // [R01] [R24]
      end else begin
         unique case (state)
            async_tx_pkg::ST_IDLE: begin
               if (load) begin
                  // Waiting for a tick keeps the start bit a full period long. [R23]
                  state <= async_tx_pkg::ST_ALIGN;
                  shift_data <= holding_data;
               end
            end
            async_tx_pkg::ST_ALIGN: begin
               if (baud_tick_in) begin
                  state <= async_tx_pkg::ST_START; // [R06]
               end
            end
            async_tx_pkg::ST_START: begin
               if (baud_tick_in) begin
                  state <= async_tx_pkg::ST_DATA;
                  bit_cnt <= 4'h0;
               end
            end
            async_tx_pkg::ST_DATA: begin
               if (baud_tick_in) begin
                  shift_data <= {1'b0, shift_data[8:1]}; // [R21]
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == last_bit) begin
                     state <= async_tx_pkg::ST_STOP;
                  end
               end
            end
            async_tx_pkg::ST_STOP: begin
               if (load) begin
                  // Back to back: the next start bit follows the stop bit with no gap. [R05] [R06]
                  state <= async_tx_pkg::ST_START;
                  shift_data <= holding_data;
               end else if (baud_tick_in) begin
                  state <= async_tx_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= async_tx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign shifter_empty = (state == async_tx_pkg::ST_IDLE); // [R14]

   // ==========================================================
   // Transmit pin
   logic mark_level;
   always_comb begin
      unique case (state)
         async_tx_pkg::ST_START: mark_level = 1'b0; // [R22]
         async_tx_pkg::ST_DATA: mark_level = shift_data[0];
         default: mark_level = 1'b1; // [R22]
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         transmit_pin_out <= 1'b1;
      end else begin
         transmit_pin_out <= line_level(mark_level, ctrl); // [R07] [R08]
      end
   end

   assign transmit_pin_oe_n_out = ~ctrl.port_enable; // [R02]

   // ==========================================================
   // Ready flag
   // The flag runs two stages behind the holding state, as software expects. [R10]
   logic ready_stage;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ready_stage <= 1'b0;
         tx_ready_flag <= 1'b0;
      end else begin
         ready_stage <= run & ~holding_full; // [R03] [R09]
         tx_ready_flag <= ready_stage;
      end
   end

   // The request is combinational so setting the enable fires it at once. [R20]
   assign tx_irq_out = tx_ready_flag & irq_control[async_tx_pkg::IRQ_READY_IE_POS] &
                       irq_control[async_tx_pkg::IRQ_PERIPH_POS] &
                       irq_control[async_tx_pkg::IRQ_GLOBAL_POS]; // [R12]

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n);

   property p_stop_when_off;
      !run |=> state == async_tx_pkg::ST_IDLE && !holding_full;
   endproperty
   a_stop_when_off: assert property (p_stop_when_off) else $error("transmitter active while off"); // [R01]

   property p_pin_driven;
      ctrl.port_enable |-> !transmit_pin_oe_n_out;
   endproperty
   a_pin_driven: assert property (p_pin_driven) else $error("pin not driven"); // [R02]

   property p_ready_on_enable;
      $rose(run) && !holding_full |-> ##2 tx_ready_flag;
   endproperty
   a_ready_on_enable: assert property (p_ready_on_enable) else $error("ready flag not set"); // [R03]

   property p_load_idle;
      hold_wr && state == async_tx_pkg::ST_IDLE && !holding_full |-> ##2 state == async_tx_pkg::ST_ALIGN;
   endproperty
   a_load_idle: assert property (p_load_idle) else $error("idle load missed"); // [R04]

   property p_back_to_back;
      run && state == async_tx_pkg::ST_STOP && baud_tick_in && holding_full
      |=> state == async_tx_pkg::ST_START && (!holding_full || $past(hold_wr));
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("queued character not moved"); // [R05]

   property p_ready_delay;
      hold_wr && !holding_full && tx_ready_flag && ready_stage &&
      state inside {async_tx_pkg::ST_ALIGN, async_tx_pkg::ST_START, async_tx_pkg::ST_DATA}
      |=> tx_ready_flag ##1 (tx_ready_flag || !run) ##1 (!tx_ready_flag || !run);
   endproperty
   a_ready_delay: assert property (p_ready_delay) else $error("ready flag timing wrong"); // [R10]

   property p_idle_level;
      state == async_tx_pkg::ST_IDLE && $stable(ctrl)
      |=> transmit_pin_out == !($past(ctrl.tx_invert) && !$past(ctrl.sync_mode));
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // [R07]

   property p_start_level;
      state == async_tx_pkg::ST_START && $stable(ctrl)
      |=> transmit_pin_out == ($past(ctrl.tx_invert) && !$past(ctrl.sync_mode));
   endproperty
   a_start_level: assert property (p_start_level) else $error("start bit level wrong"); // [R22]

   property p_nine_bits;
      run && state == async_tx_pkg::ST_DATA && baud_tick_in && bit_cnt == 4'h7 && ctrl.nine_bit_tx_select
      |=> state == async_tx_pkg::ST_DATA;
   endproperty
   a_nine_bits: assert property (p_nine_bits) else $error("ninth bit skipped"); // [R16]

   property p_empty_clears;
      run && load |=> !shifter_empty;
   endproperty
   a_empty_clears: assert property (p_empty_clears) else $error("empty bit not cleared"); // [R14]

   property p_irq_gate;
      tx_irq_out |-> tx_ready_flag && irq_control[async_tx_pkg::IRQ_READY_IE_POS];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable"); // [R12]

   c_back_to_back: cover property (state == async_tx_pkg::ST_STOP && load);
   c_nine_bit: cover property (state == async_tx_pkg::ST_DATA && bit_cnt == 4'h8);
   c_inverted: cover property (state == async_tx_pkg::ST_START && ctrl.tx_invert);
   c_irq: cover property (tx_irq_out);
endmodule

// file: dv/serial_rx_model.sv
// Behavioural remote receiver that watches the transmit line and collects characters.
`timescale 1ns/1ps
module serial_rx_model #(
   parameter int BIT_CYCLES = 16
) (
   // Clock
   input wire logic clk_in,
   // Line and expected format
   input wire logic line_in,
   input wire logic invert_in,
   input wire logic nine_in,
   // Received character
   output logic [8:0] rx_data_out,
   output logic rx_frame_ok_out,
   output int rx_count_out
);
   // ==========================================================
   // Receiver
   logic mark_lvl;
   logic [8:0] data;
   int i;
   assign mark_lvl = ~invert_in;
   initial begin
      rx_count_out = 0;
      rx_data_out = '0;
      rx_frame_ok_out = 1'b0;
      forever begin
         @(posedge clk_in);
         if (line_in !== mark_lvl) begin
            // A start bit is only believed at its middle, so a polarity change or glitch is not taken as data.
            repeat (BIT_CYCLES / 2) @(posedge clk_in);
            if (line_in === ~mark_lvl) begin
               data = '0;
               for (i = 0; i < (nine_in ? 9 : 8); i++) begin
                  repeat (BIT_CYCLES) @(posedge clk_in);
                  data[i] = (line_in === mark_lvl);
               end
               repeat (BIT_CYCLES) @(posedge clk_in);
               rx_frame_ok_out = (line_in === mark_lvl);
               rx_data_out = data;
               rx_count_out++;
            end
         end
      end
   end
endmodule

// file: dv/async_serial_transmitter_bench.sv
// Self-checking bench of the asynchronous serial transmitter.
`timescale 1ns/1ps
module async_serial_transmitter_bench;
   localparam int TICK = 16;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic tick = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, hs, ws, pin, oe_n, irq, line, rx_ok, err;
   logic inv = 1'b0;
   logic nine = 1'b0;
   logic [15:0] div;
   logic [8:0] rx_data;
   logic [31:0] seed = 32'hEC1F2AEE;
   logic [31:0] rd;
   logic [7:0] c0, c1;
   logic [7:0] addrs [7];
   logic [7:0] rst_v [7];
   logic [7:0] full_v [7];
   int rx_count, n_fail, num_checks, tcnt, base, j;
   // ==========================================================
   // Clock, bit-rate tick and line with pull-up
   always #25 clk = ~clk;
   always @(posedge clk) begin
      tcnt <= (tcnt == TICK - 1) ? 0 : tcnt + 1;
      tick <= (tcnt == TICK - 1);
   end
   assign line = oe_n ? 1'b1 : pin;
   async_serial_transmitter async_serial_transmitter_inst (
      .sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .baud_tick_in(tick), .baud_divisor_out(div), .baud_high_speed_out(hs), .baud_wide_select_out(ws),
      .transmit_pin_out(pin), .transmit_pin_oe_n_out(oe_n), .tx_irq_out(irq));
   serial_rx_model #(.BIT_CYCLES(TICK)) serial_rx_model_inst (
      .clk_in(clk), .line_in(line), .invert_in(inv), .nine_in(nine),
      .rx_data_out(rx_data), .rx_frame_ok_out(rx_ok), .rx_count_out(rx_count));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [8:0] exp_char(input logic [7:0] d, input logic b9, input logic nb);
      return nb ? {b9, d} : {1'b0, d};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 100) begin
         @(posedge clk);
         k++;
      end
      if (k >= 100) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      @(posedge clk);
   endtask
   task automatic rx_expect(input int n, input logic [8:0] e);
      int k;
      k = 0;
      while (rx_count < n && k < 4000) begin
         @(posedge clk);
         k++;
      end
      chk(rx_count >= n, 1'b1, "character arrived");
      chk(rx_data, e, "received character");
      chk(rx_ok, 1'b1, "stop bit level");
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      summarize();
   end
   // ==========================================================
   // Tests
   initial begin
      addrs = '{async_tx_pkg::ADDR_BAUD_CONTROL, async_tx_pkg::ADDR_RX_STATUS_CONTROL,
                async_tx_pkg::ADDR_BAUD_DIVISOR_LOW, async_tx_pkg::ADDR_BAUD_DIVISOR_HIGH,
                async_tx_pkg::ADDR_TX_HOLDING_DATA, async_tx_pkg::ADDR_TX_STATUS_CONTROL,
                async_tx_pkg::ADDR_IRQ_CONTROL};
      rst_v = '{async_tx_pkg::BAUD_RESET, async_tx_pkg::RSC_RESET, async_tx_pkg::DIVISOR_RESET,
                async_tx_pkg::DIVISOR_RESET, 8'h00, async_tx_pkg::TSC_RESET | 8'h02, async_tx_pkg::IRQ_RESET};
      full_v = '{async_tx_pkg::BAUD_WR_MASK, async_tx_pkg::RSC_WR_MASK, 8'hFF, 8'hFF, 8'h00,
                 async_tx_pkg::TSC_WR_MASK | 8'h02, async_tx_pkg::IRQ_WR_MASK};
      repeat (20) @(posedge clk);
      chk({oe_n, pin}, 2'b11, "pin during reset");
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      for (j = 0; j < 7; j++) begin
         apb(1'b0, addrs[j], 32'h0);
         chk(rd, {24'h0, rst_v[j]}, "reset value");
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      chk(err, 1'b1, "unmapped error");
      for (j = 0; j < 7; j++) wr(addrs[j], 8'hFF);
      for (j = 0; j < 7; j++) begin
         apb(1'b0, addrs[j], 32'h0);
         chk(rd, {24'h0, full_v[j]}, "read-only bits kept");
      end
      chk({div, hs, ws, irq}, {16'hFFFF, 3'b110}, "baud outputs");
      for (j = 0; j < 7; j++) wr(addrs[j], 8'h00);
      repeat (400) @(posedge clk);
      // Setup order: divisor, async port enable, then transmit enable.
      wr(async_tx_pkg::ADDR_BAUD_DIVISOR_LOW, 8'h19);
      wr(async_tx_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
      chk(oe_n, 1'b0, "pin driven");
      wr(async_tx_pkg::ADDR_TX_STATUS_CONTROL, 8'h20);
      repeat (3) @(posedge clk);
      apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::IRQ_FLAG_POS], 1'b1, "ready flag after enable");
      wr(async_tx_pkg::ADDR_IRQ_CONTROL, 8'hC1);
      chk(irq, 1'b1, "interrupt at once");
      wr(async_tx_pkg::ADDR_IRQ_CONTROL, 8'hC0);
      apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
      chk({irq, rd[async_tx_pkg::IRQ_FLAG_POS]}, 2'b01, "flag without enable");
      wr(async_tx_pkg::ADDR_IRQ_CONTROL, 8'hC1);
      for (j = 0; j < 3; j++) begin
         seed = xs(seed);
         c0 = seed[7:0];
         c1 = seed[15:8];
         base = rx_count;
         wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, c0);
         wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, c1);
         apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
         chk({irq, rd[async_tx_pkg::IRQ_FLAG_POS]}, 2'b00, "flag with queued char");
         apb(1'b0, async_tx_pkg::ADDR_TX_STATUS_CONTROL, 32'h0);
         chk(rd[async_tx_pkg::TSC_EMPTY_POS], 1'b0, "shifter busy");
         rx_expect(base + 1, exp_char(c0, 1'b0, 1'b0));
         rx_expect(base + 2, exp_char(c1, 1'b0, 1'b0));
      end
      wr(async_tx_pkg::ADDR_IRQ_CONTROL, 8'hC0);
      repeat (2 * TICK) @(posedge clk);
      apb(1'b0, async_tx_pkg::ADDR_TX_STATUS_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::TSC_EMPTY_POS], 1'b1, "shifter empty after frame");
      nine = 1'b1;
      for (j = 0; j < 2; j++) begin
         seed = xs(seed);
         base = rx_count;
         wr(async_tx_pkg::ADDR_TX_STATUS_CONTROL, 8'h60 | j[0]);
         wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, seed[7:0]);
         rx_expect(base + 1, exp_char(seed[7:0], j[0], 1'b1));
      end
      nine = 1'b0;
      wr(async_tx_pkg::ADDR_TX_STATUS_CONTROL, 8'h20);
      wr(async_tx_pkg::ADDR_BAUD_CONTROL, 8'h10);
      inv = 1'b1;
      repeat (40) @(posedge clk);
      chk(pin, 1'b0, "inverted idle");
      seed = xs(seed);
      base = rx_count;
      wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, seed[7:0]);
      rx_expect(base + 1, exp_char(seed[7:0], 1'b0, 1'b0));
      wr(async_tx_pkg::ADDR_BAUD_CONTROL, 8'h00);
      inv = 1'b0;
      wr(async_tx_pkg::ADDR_TX_STATUS_CONTROL, 8'h30);
      apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::IRQ_FLAG_POS], 1'b0, "clocked mode stops");
      wr(async_tx_pkg::ADDR_TX_STATUS_CONTROL, 8'h20);
      repeat (40) @(posedge clk);
      // Abort in mid-character; the receiver may report a broken frame, which is not judged.
      wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, 8'hA5);
      wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, 8'h3C);
      repeat (60) @(posedge clk);
      wr(async_tx_pkg::ADDR_RX_STATUS_CONTROL, 8'h00);
      chk(oe_n, 1'b1, "pin released");
      apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::IRQ_FLAG_POS], 1'b0, "flag with port off");
      wr(async_tx_pkg::ADDR_TX_HOLDING_DATA, 8'h5A);
      repeat (400) @(posedge clk);
      base = rx_count;
      wr(async_tx_pkg::ADDR_RX_STATUS_CONTROL, 8'h80);
      repeat (3) @(posedge clk);
      apb(1'b0, async_tx_pkg::ADDR_TX_STATUS_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::TSC_EMPTY_POS], 1'b1, "shifter emptied");
      apb(1'b0, async_tx_pkg::ADDR_IRQ_CONTROL, 32'h0);
      chk(rd[async_tx_pkg::IRQ_FLAG_POS], 1'b1, "holding emptied");
      repeat (300) @(posedge clk);
      chk(rx_count - base, 0, "nothing sent after abort");
      summarize();
   end
endmodule
